// file: dram_power_down_and_reset.sv
// power-down state handling and reset behaviour of a ddr3 memory device
//
// Functional notes
// [R1] cke sampled low with nop/des enters power-down; never during mrs/read/write
// [R2] controller waits one clock after act/pre/ref, tmod after mrs, before cke low
// [R3] refresh between exit and entry: controller waits max(10 clocks, 24 ns)
// [R4] write-auto-precharge entry uses mode register write recovery count
// [R5] fixed chop-four lets controller drop cke two clocks earlier after writes
// [R6] power-down disables buffers except clock, termination, cke and reset
// [R7] controller issues only nop/des until tcpded after entry
// [R8] unlocked dll at entry must be reset after exit before reads
// [R9] any bank open at entry gives active power-down, dll kept on
// [R10] all banks closed at entry gives precharge power-down
// [R11] precharge power-down: mode bit 1 keeps dll on, 0 turns it off
// [R12] slow exit: txpdll before read or termination-on, txp before others
// [R13] slow exit: termination asynchronous until tanpd plus txpdll after exit; code ends it txpdll after exit, without tanpd
// [R14] controller holds cke low, reset high, clock stable during power-down
// [R15] reset low during power-down leaves power-down for reset state
// [R16] controller keeps cke low at least tpd min, at most nine refresh intervals
// [R17] cke sampled high with nop/des exits; cke then stays high tcke
// [R18] controller issues executable command only after txp and txpdll
// [R19] controller meets txp before a refresh between exit and entry
// [R20] controller meets txpdll from exit before next entry
// [R21] falling reset acts as reset at any time
// [R22] controller holds reset low at least 100 ns
// [R23] reset low disables outputs and turns termination off
// [R24] controller should drive cke low before releasing reset
// [R25] after reset, refresh counters cleared and data unknown; re-init needed
// [R26] controller tracks per-command timers before lowering cke; model uses one count of twelve quiet clocks for every command
`timescale 1ns/1ps
`include "dram_pd_map.svh"
module dram_power_down_and_reset
  import dram_pd_pkg::*;
#(
  parameter int BANKS = 8,
  parameter int REF_CNT_W = 16
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // pins from controller
  input wire logic reset_n_i,
  input wire logic cke_i,
  input wire logic [2:0] cmd_i,
  input wire logic [2:0] bank_i,
  input wire logic [`MR_ADDR_W-1:0] addr_i,
  input wire logic busy_i,
  // status
  output logic powered_down_o,
  output logic active_pd_o,
  output logic dll_on_o,
  output logic buf_en_o,
  output logic odt_async_o,
  output logic term_off_o,
  output logic out_en_o,
  output logic in_reset_o,
  output logic cmd_ready_o,
  output logic dll_ready_o,
  output logic [REF_CNT_W-1:0] ref_count_o
);
  // ==========================================
  // pin synchronisers
  // ==========================================
  // reset pin comes from outside: three stages, change counted when last two agree
  logic [2:0] rst_sync;
  logic rst_low;
  logic [2:0] next_rst_sync;
  logic next_rst_low;
  always_comb begin
    next_rst_sync = {rst_sync[1:0], reset_n_i};
    next_rst_low = rst_low;
    if (rst_sync[2] == rst_sync[1]) begin
      next_rst_low = ~rst_sync[2];
    end
  end
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rst_sync <= 3'h0;
      rst_low <= 1'b1;
    end else begin
      rst_sync <= next_rst_sync;
      rst_low <= next_rst_low;
    end
  end

  // ==========================================
  // mode register, open banks, timers
  // ==========================================
  function automatic logic [3:0] sat_dec(input logic [3:0] v);
    sat_dec = (v == 4'h0) ? 4'h0 : v - 4'h1;
  endfunction

  pd_state_e state, next_state;
  logic [`MR_ADDR_W-1:0] mr0, next_mr0;
  logic [BANKS-1:0] open_banks, next_open_banks;
  logic [3:0] xp_cnt, next_xp_cnt;
  logic [3:0] xpdll_cnt, next_xpdll_cnt;
  logic [3:0] cked_cnt, next_cked_cnt;
  logic [REF_CNT_W-1:0] ref_count, next_ref_count;
  logic nop_like;
  cmd_e cmd;

  assign cmd = cmd_e'(cmd_i);
  assign nop_like = (cmd == CMD_NOP) || (cmd == CMD_DES);

  always_comb begin
    next_state = state;
    next_mr0 = mr0;
    next_open_banks = open_banks;
    next_xp_cnt = sat_dec(xp_cnt);
    next_xpdll_cnt = sat_dec(xpdll_cnt);
    next_cked_cnt = sat_dec(cked_cnt);
    next_ref_count = ref_count;
    unique case (state)
      ST_RESET: begin
        next_open_banks = '0; // see [R25]
        next_ref_count = '0; // see [R25]
        next_mr0 = `MR0_RESET;
        if (!rst_low) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        // entry refused while an operation is still busy
        if (!cke_i && nop_like && !busy_i && cked_cnt == 4'h0) begin // see [R1]
          if (|open_banks) begin
            next_state = ST_APD; // see [R9]
          end else if (mr0[`MR0_PPD_BIT]) begin // see [R10]
            next_state = ST_PPD_FAST; // see [R11]
          end else begin
            next_state = ST_PPD_SLOW; // see [R11]
          end
        end else if (cke_i) begin
          unique case (cmd)
            CMD_ACT: next_open_banks[bank_i] = 1'b1;
            CMD_PRE: begin
              if (addr_i[`PRE_ALL_BIT]) begin
                next_open_banks = '0;
              end else begin
                next_open_banks[bank_i] = 1'b0;
              end
            end
            CMD_REF: next_ref_count = ref_count + 1'b1;
            CMD_MRS: begin
              if (bank_i == 3'h0) begin
                next_mr0 = addr_i;
              end
            end
            default: begin
            end
          endcase
        end
      end
      ST_APD, ST_PPD_FAST, ST_PPD_SLOW: begin
        if (cke_i && nop_like) begin // see [R17]
          next_state = ST_RUN;
          next_xp_cnt = 4'(`TXP_CYC);
          next_xpdll_cnt = 4'(`TXPDLL_CYC);
          // cke must stay high tcke before a new entry is honoured
          next_cked_cnt = 4'(`TCKE_CYC); // see [R17]
        end
      end
      default: next_state = ST_RESET;
    endcase
    if (rst_low) begin
      next_state = ST_RESET; // see [R15] see [R21]
      // cleared on the very edge the pin takes effect, not one state later
      next_open_banks = '0; // see [R25]
      next_ref_count = '0; // see [R25]
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state <= ST_RESET;
      mr0 <= `MR0_RESET;
      open_banks <= '0;
      xp_cnt <= 4'h0;
      xpdll_cnt <= 4'h0;
      cked_cnt <= 4'h0;
      ref_count <= '0;
    end else begin
      state <= next_state;
      mr0 <= next_mr0;
      open_banks <= next_open_banks;
      xp_cnt <= next_xp_cnt;
      xpdll_cnt <= next_xpdll_cnt;
      cked_cnt <= next_cked_cnt;
      ref_count <= next_ref_count;
    end
  end

  // ==========================================
  // registered status outputs
  // ==========================================
  logic slow_exit, next_slow_exit;
  logic in_pd;
  assign in_pd = (next_state == ST_APD) || (next_state == ST_PPD_FAST) ||
                 (next_state == ST_PPD_SLOW);
  always_comb begin
    next_slow_exit = slow_exit;
    if (next_state == ST_PPD_SLOW) begin
      next_slow_exit = 1'b1;
    end else if (next_state == ST_RESET || (next_xpdll_cnt == 4'h0 && !in_pd)) begin
      next_slow_exit = 1'b0;
    end
  end
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      slow_exit <= 1'b0;
      powered_down_o <= 1'b0;
      active_pd_o <= 1'b0;
      dll_on_o <= 1'b0;
      buf_en_o <= 1'b0;
      odt_async_o <= 1'b0;
      term_off_o <= 1'b1;
      out_en_o <= 1'b0;
      in_reset_o <= 1'b1;
      cmd_ready_o <= 1'b0;
      dll_ready_o <= 1'b0;
      ref_count_o <= '0;
    end else begin
      slow_exit <= next_slow_exit;
      powered_down_o <= in_pd;
      active_pd_o <= (next_state == ST_APD); // see [R9]
      // dll off only in slow-exit precharge power-down and reset
      dll_on_o <= (next_state != ST_PPD_SLOW) && (next_state != ST_RESET); // see [R11]
      buf_en_o <= !in_pd && (next_state != ST_RESET); // see [R6]
      // termination stays asynchronous through the txpdll window after exit
      odt_async_o <= next_slow_exit; // see [R13]
      term_off_o <= (next_state == ST_RESET); // see [R23]
      out_en_o <= (next_state == ST_RUN) && (next_xp_cnt == 4'h0); // see [R23]
      in_reset_o <= (next_state == ST_RESET);
      cmd_ready_o <= (next_state == ST_RUN) && (next_xp_cnt == 4'h0);
      dll_ready_o <= (next_state == ST_RUN) && (next_xpdll_cnt == 4'h0);
      ref_count_o <= next_ref_count;
    end
  end
endmodule

// file: dram_pd_map.svh
// timing counts and field positions for the dram power-down and reset block
`ifndef DRAM_PD_MAP_SVH
`define DRAM_PD_MAP_SVH
// address and mode register field positions
`define MR_ADDR_W 14
`define PRE_ALL_BIT 10
`define MR0_PPD_BIT 12
`define MR0_WR_HI 11
`define MR0_WR_LO 9
`define MR0_BL_HI 1
`define MR0_BL_LO 0
`define MR0_BL_CHOP4 2'h2
// timing figures
`define CLK_PERIOD_PS 50000
`define RESET_LOW_NS 100
`define RESET_LOW_CYC ((`RESET_LOW_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define TXP_CYC 3
`define TXPDLL_CYC 10
`define TCPDED_CYC 1
`define TCKE_CYC 3
// reset values
`define MR0_RESET 14'h0000
`endif

// file: dram_pd_pkg.sv
// types for the dram power-down and reset block
package dram_pd_pkg;
  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_DES = 3'h1,
    CMD_ACT = 3'h2,
    CMD_PRE = 3'h3,
    CMD_REF = 3'h4,
    CMD_MRS = 3'h5,
    CMD_RD = 3'h6,
    CMD_WR = 3'h7
  } cmd_e;
  typedef enum logic [4:0] {
    ST_RESET = 5'h01,
    ST_RUN = 5'h02,
    ST_APD = 5'h04,
    ST_PPD_FAST = 5'h08,
    ST_PPD_SLOW = 5'h10
  } pd_state_e;
endpackage

// file: dram_pd_assertions.sv
// checker for the dram power-down and reset block
`timescale 1ns/1ps
module dram_pd_assertions #(
  parameter int REF_CNT_W = 16
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // pins and status
  input wire logic reset_n_i,
  input wire logic cke_i,
  input wire logic [2:0] cmd_i,
  input wire logic busy_i,
  input wire logic powered_down_o,
  input wire logic active_pd_o,
  input wire logic dll_on_o,
  input wire logic buf_en_o,
  input wire logic odt_async_o,
  input wire logic term_off_o,
  input wire logic out_en_o,
  input wire logic in_reset_o,
  input wire logic cmd_ready_o,
  input wire logic dll_ready_o,
  input wire logic [REF_CNT_W-1:0] ref_count_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  // ==========================================
  // entry and exit
  sequence s_entry;
    !cke_i && cmd_i <= 3'h1 && !busy_i && reset_n_i && !powered_down_o && !in_reset_o
      && $past(cke_i) && $past(cke_i, 2) && $past(cke_i, 3) && $past(cke_i, 4);
  endsequence
  sequence s_exit;
    $fell(powered_down_o) && !in_reset_o;
  endsequence
  sequence s_slow_exit;
    $fell(powered_down_o) && !in_reset_o && odt_async_o;
  endsequence
  entry_taken_a: assert property (s_entry |=> powered_down_o)
    else $error("entry not taken");
  busy_blocks_a: assert property (busy_i && !powered_down_o |=> !powered_down_o)
    else $error("entry while busy");
  exit_taken_a: assert property (powered_down_o && cke_i && cmd_i <= 3'h1 |=> !powered_down_o)
    else $error("exit not taken");
  buf_off_a: assert property (powered_down_o |-> !buf_en_o)
    else $error("buffers on in power-down");
  apd_dll_a: assert property (active_pd_o |-> powered_down_o && dll_on_o)
    else $error("active power-down without dll");
  slow_odt_a: assert property ($rose(powered_down_o) && !dll_on_o |-> odt_async_o)
    else $error("termination not asynchronous");
  odt_hold_a: assert property (s_slow_exit |-> odt_async_o[*8] ##1 odt_async_o[*2] ##1 !odt_async_o)
    else $error("asynchronous termination span wrong");
  ready_gap_a: assert property (s_exit |-> !cmd_ready_o ##3 cmd_ready_o)
    else $error("command ready timing wrong");
  dll_gap_a: assert property (s_exit |-> !dll_ready_o ##10 dll_ready_o)
    else $error("dll ready timing wrong");
  reset_seen_a: assert property ($fell(reset_n_i) |-> ##[1:5] in_reset_o)
    else $error("reset pin not honoured");
  reset_quiet_a: assert property (in_reset_o |-> term_off_o && !out_en_o
    && !powered_down_o && ref_count_o == '0)
    else $error("reset state outputs wrong");
endmodule
bind dram_power_down_and_reset dram_pd_assertions #(.REF_CNT_W(REF_CNT_W)) chk_i (
  .clock_i, .srst_i, .reset_n_i, .cke_i, .cmd_i, .busy_i, .powered_down_o, .active_pd_o,
  .dll_on_o, .buf_en_o, .odt_async_o, .term_off_o, .out_en_o, .in_reset_o, .cmd_ready_o,
  .dll_ready_o, .ref_count_o);

// file: dram_ctrl_model.sv
// controller-side model driving clock-enable and commands
`timescale 1ns/1ps
module dram_ctrl_model (
  // clock
  input wire logic clock_i,
  // requests from the bench
  input wire logic pd_req_i,
  input wire logic [2:0] cmd_req_i,
  // pins to the device
  output logic cke_o,
  output logic [2:0] cmd_o
);
  // twelve quiet clocks cover tmod, txpdll, tcke and write recovery with margin
  localparam int HOLD = 12;
  int gap = 0;
  // declaration initialisers keep one procedural driver per pin
  logic cke_r = 1'b1;
  logic [2:0] cmd_r = 3'h0;
  assign cke_o = cke_r;
  assign cmd_o = cmd_r;
  always @(negedge clock_i) begin
    if (pd_req_i && (!cke_r || gap >= HOLD)) begin
      cke_r <= 1'b0;
      cmd_r <= 3'h0;
      gap <= 0;
    end else begin
      cke_r <= 1'b1;
      cmd_r <= cke_r ? cmd_req_i : 3'h0;
      gap <= (cke_r && cmd_req_i == 3'h0) ? gap + 1 : 0;
    end
  end
endmodule

// file: test_dram_power_down_and_reset.sv
// testbench for the dram power-down and reset block
`timescale 1ns/1ps
module test_dram_power_down_and_reset;
  import dram_pd_pkg::*;
  logic clock_i, srst_i, reset_n_i, cke_i, busy_i, pd_req;
  logic [2:0] cmd_i, bank_i, cmd_req;
  logic [13:0] addr_i;
  logic powered_down_o, active_pd_o, dll_on_o, buf_en_o, odt_async_o, term_off_o;
  logic out_en_o, in_reset_o, cmd_ready_o, dll_ready_o;
  logic [15:0] ref_count_o;
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  dram_power_down_and_reset dram_power_down_and_reset_i (.clock_i, .srst_i, .reset_n_i,
    .cke_i, .cmd_i, .bank_i, .addr_i, .busy_i, .powered_down_o, .active_pd_o, .dll_on_o,
    .buf_en_o, .odt_async_o, .term_off_o, .out_en_o, .in_reset_o, .cmd_ready_o,
    .dll_ready_o, .ref_count_o);
  dram_ctrl_model dram_ctrl_model_i (.clock_i, .pd_req_i(pd_req), .cmd_req_i(cmd_req),
    .cke_o(cke_i), .cmd_o(cmd_i));
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  // ==========================================
  // helpers
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic issue(input logic [2:0] c, input logic [13:0] a);
    @(negedge clock_i);
    cmd_req <= c;
    addr_i <= a;
    @(negedge clock_i);
    cmd_req <= CMD_NOP;
    repeat (3) @(negedge clock_i);
  endtask
  task automatic wait_pd(input logic lvl);
    int n;
    n = 0;
    pd_req <= lvl;
    @(negedge clock_i);
    while (powered_down_o !== lvl && n < 40) begin
      @(negedge clock_i);
      n++;
    end
    chk("powered_down", powered_down_o, lvl);
  endtask
  // ==========================================
  // scenarios
  task automatic t_apd();
    issue(CMD_ACT, 14'h0000);
    wait_pd(1'b1);
    chk("active_pd", active_pd_o, 1'b1);
    chk("dll_on", dll_on_o, 1'b1);
    chk("buf_en", buf_en_o, 1'b0);
    wait_pd(1'b0);
    chk("cmd_ready", cmd_ready_o, 1'b0);
    repeat (2) @(negedge clock_i);
    chk("cmd_ready", cmd_ready_o, 1'b0);
    @(negedge clock_i);
    chk("cmd_ready", cmd_ready_o, 1'b1);
    chk("buf_en", buf_en_o, 1'b1);
    chk("out_en", out_en_o, 1'b1);
    chk("term_off", term_off_o, 1'b0);
    $display("done active power-down");
  endtask
  task automatic t_ppd(input logic fast);
    issue(CMD_PRE, 14'h0400);
    issue(CMD_MRS, fast ? 14'h1000 : 14'h0000);
    wait_pd(1'b1);
    chk("active_pd", active_pd_o, 1'b0);
    chk("dll_on", dll_on_o, fast);
    chk("odt_async", odt_async_o, !fast);
    wait_pd(1'b0);
    repeat (9) @(negedge clock_i);
    chk("odt_async", odt_async_o, !fast);
    chk("dll_ready", dll_ready_o, 1'b0);
    @(negedge clock_i);
    chk("dll_ready", dll_ready_o, 1'b1);
    $display("done precharge power-down");
  endtask
  task automatic t_busy();
    busy_i <= 1'b1;
    pd_req <= 1'b1;
    repeat (20) @(negedge clock_i);
    chk("powered_down", powered_down_o, 1'b0);
    busy_i <= 1'b0;
    wait_pd(1'b1);
    wait_pd(1'b0);
    repeat (12) @(negedge clock_i);
    $display("done busy");
  endtask
  task automatic t_reset();
    int n;
    issue(CMD_REF, 14'h0000);
    chk("ref_count", ref_count_o, 16'h0001);
    wait_pd(1'b1);
    reset_n_i <= 1'b0;
    repeat (8) @(negedge clock_i);
    chk("in_reset", in_reset_o, 1'b1);
    chk("powered_down", powered_down_o, 1'b0);
    chk("term_off", term_off_o, 1'b1);
    chk("out_en", out_en_o, 1'b0);
    chk("ref_count", ref_count_o, 16'h0000);
    reset_n_i <= 1'b1;
    n = 0;
    while (in_reset_o !== 1'b0 && n < 20) begin
      @(negedge clock_i);
      n++;
    end
    chk("in_reset", in_reset_o, 1'b0);
    pd_req <= 1'b0;
    repeat (16) @(negedge clock_i);
    $display("done reset");
  endtask
  // ==========================================
  // sequence and timeout
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      close_out();
    end
  end
  initial begin
    {srst_i, reset_n_i, busy_i, pd_req} = 4'hC;
    {cmd_req, bank_i, addr_i} = '0;
    repeat (16) @(negedge clock_i);
    srst_i <= 1'b0;
    repeat (16) @(negedge clock_i);
    chk("in_reset", in_reset_o, 1'b0);
    t_apd();
    t_ppd(1'b1);
    t_ppd(1'b0);
    t_busy();
    t_reset();
    close_out();
  end
endmodule
